/* hdl/ccs_pkg.sv */
package ccs_pkg;

    // 8-bit slave address with the direction bit clear (write form)
    localparam logic [7:0]  SLAVE_ADDR8   = 8'HD2;
    // number of configuration bytes behind the serial port
    localparam int          REG_COUNT     = 8;
    localparam logic [7:0]  COUNT_BYTE    = 8'(REG_COUNT);
    localparam int          REG_AW        = $clog2(REG_COUNT);
    // power-up contents, byte 7 down to byte 0
    localparam logic [63:0] REG_DEFAULTS  = {8'H00, 8'H00, 8'H00, 8'H07,
                                             8'H00, 8'HFF, 8'HF6, 8'HFF};
    // plain two-wire mode: when set, block writes carry no byte count
    localparam int          PLAIN_BYTE    = 7;
    localparam int          PLAIN_BIT     = 0;
    // command byte layout
    localparam int          CMD_SINGLE    = 7;
    localparam int          IDX_W         = 7;
    // write stream buffer between the serial side and the byte store
    localparam int          FIFO_WIDTH    = IDX_W + 8;
    localparam int          FIFO_DEPTH    = 16;
    // bit counter values
    localparam logic [3:0]  BITS_DONE     = 4'H8;
    localparam logic [3:0]  ACK_SEEN      = 4'H1;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'H01,
        ST_RX     = 6'H02,
        ST_ACK    = 6'H04,
        ST_TX     = 6'H08,
        ST_RACK   = 6'H10,
        ST_IGNORE = 6'H20
    } ccs_state_t;

    typedef enum logic [3:0] {
        PH_ADDR  = 4'H1,
        PH_CMD   = 4'H2,
        PH_COUNT = 4'H4,
        PH_DATA  = 4'H8
    } ccs_phase_t;

endpackage

/* hdl/ccs_fifo.sv */
`timescale 1ns/10ps
module ccs_fifo #(
    parameter int WIDTH = ccs_pkg::FIFO_WIDTH,
    parameter int DEPTH = ccs_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 used;
    } ccs_fifo_st_t;

    ccs_fifo_st_t r;
    ccs_fifo_st_t next_r;
    logic         push;
    logic         pop;

    // honest flags straight from the fill level
    assign in_ready  = r.used != (AW+1)'(DEPTH);
    assign out_valid = r.used != '0;
    assign out_data  = r.mem[r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and level update
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp        = r.wp + 1'b1;
        end
        if (pop) begin
            next_r.rp = r.rp + 1'b1;
        end
        next_r.used = r.used + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

/* hdl/ccs_regs.sv */
`timescale 1ns/10ps
module ccs_regs (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        rd,
    input  wire logic                        we,
    input  wire logic [ccs_pkg::IDX_W-1:0]   addr,
    input  wire logic [7:0]                  wdata,
    output logic      [7:0]                  rdata,
    output logic      [ccs_pkg::REG_COUNT*8-1:0] bytes
);
    typedef struct packed {
        logic [ccs_pkg::REG_COUNT-1:0][7:0] mem;
        logic [7:0]                         rdata;
    } ccs_regs_st_t;

    ccs_regs_st_t r;
    ccs_regs_st_t next_r;
    logic         in_range;

    assign in_range = addr < ccs_pkg::IDX_W'(ccs_pkg::REG_COUNT);
    assign rdata    = r.rdata;
    assign bytes    = r.mem;

    // single port: bytes past the end read as zero and drop writes
    always_comb begin
        next_r = r;
        if (rd) begin
            next_r.rdata = in_range ? r.mem[addr[ccs_pkg::REG_AW-1:0]] : 8'H00;
        end else if (we && in_range) begin
            next_r.mem[addr[ccs_pkg::REG_AW-1:0]] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r.mem   <= ccs_pkg::REG_DEFAULTS;
            r.rdata <= 8'H00;
        end else begin
            r <= next_r;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    reset_defaults_a: assert property ($rose(!reset) |-> bytes == ccs_pkg::REG_DEFAULTS)
        else $error("config bytes not at defaults after reset");

endmodule

/* hdl/ccs_slave.sv */
`timescale 1ns/10ps
// Contract
// - answer only the fixed slave address, D2h in its 8-bit write form
// - accept byte write, byte read, block write and block read
// - command bit 7 clear picks block access, set picks one indexed byte
// - command bits 6:0 index the byte; block access expects them zero
// - block access walks bytes upward from byte zero, msb first, any stop
// - all serial registers take their defaults at power-up
// - address, write bit, ack, then command byte with ack open every block
// - block write carries an acked count byte unless plain mode is set
// - block write data bytes each acked, stop ends the transfer
// - block read uses repeated start and read-direction address, acked
// - block read returns a byte count first, acked by the controller
// - block read data acked except last, which gets not-ack then stop
// - byte write and byte read follow the same framing for one byte
module ccs_slave (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    output logic [63:0]      CFG
);
    typedef struct packed {
        logic [2:0]          scl_s;
        logic [2:0]          sda_s;
        logic                scl_f;
        logic                sda_f;
        logic                scl_d;
        logic                sda_d;
        ccs_pkg::ccs_state_t state;
        ccs_pkg::ccs_phase_t phase;
        logic [3:0]          cnt;
        logic [7:0]          shreg;
        logic                rw;
        logic                single;
        logic                cnt_sent;
        logic                nack;
        logic [6:0]          index;
        logic                oe;
    } ccs_slave_st_t;

    ccs_slave_st_t r;
    ccs_slave_st_t next_r;

    logic                              scl_rise;
    logic                              scl_fall;
    logic                              start_seen;
    logic                              stop_seen;
    logic                              plain_mode;
    logic                              dec_rx;
    logic                              addr_match;
    logic                              do_load;
    logic [7:0]                        tx_byte;
    logic                              mem_rd;
    logic [7:0]                        mem_rdata;
    logic                              fifo_in_valid;
    logic                              fifo_in_ready;
    logic                              fifo_out_valid;
    logic                              fifo_out_ready;
    logic [ccs_pkg::FIFO_WIDTH-1:0]    fifo_out_data;

    // line events from the filtered levels; both lines share one filter delay
    assign scl_rise   = r.scl_f & ~r.scl_d;
    assign scl_fall   = ~r.scl_f & r.scl_d;
    assign start_seen = r.scl_f & r.scl_d & ~r.sda_f & r.sda_d;
    assign stop_seen  = r.scl_f & r.scl_d & r.sda_f & ~r.sda_d;
    assign plain_mode = CFG[ccs_pkg::PLAIN_BYTE*8+ccs_pkg::PLAIN_BIT];
    assign dec_rx     = (r.state == ccs_pkg::ST_RX) && scl_fall && (r.cnt == ccs_pkg::BITS_DONE);
    assign addr_match = r.shreg[7:1] == ccs_pkg::SLAVE_ADDR8[7:1];

    // count byte goes out ahead of block data
    assign tx_byte = (!r.single && !r.cnt_sent) ? ccs_pkg::COUNT_BYTE : mem_rdata;

    // open drain: only ever pulls low
    assign SDA_OUT = 1'B0;
    assign SDA_OE  = r.oe;

    // reads win the single store port; the write stream waits in the buffer
    assign mem_rd         = (r.state == ccs_pkg::ST_ACK) || (r.state == ccs_pkg::ST_RACK);
    assign fifo_out_ready = ~mem_rd;
    assign fifo_in_valid  = dec_rx && (r.phase == ccs_pkg::PH_DATA);

    // bit engine and framing
    always_comb begin
        next_r   = r;
        do_load  = 1'b0;
        // pin synchronisers; a level counts once stages two and three agree
        next_r.scl_s = {r.scl_s[1:0], SCL};
        next_r.sda_s = {r.sda_s[1:0], SDA_IN};
        if (r.scl_s[1] == r.scl_s[2]) begin
            next_r.scl_f = r.scl_s[2];
        end
        if (r.sda_s[1] == r.sda_s[2]) begin
            next_r.sda_f = r.sda_s[2];
        end
        next_r.scl_d = r.scl_f;
        next_r.sda_d = r.sda_f;

        case (r.state)
            ccs_pkg::ST_RX: begin
                if (scl_rise && r.cnt != ccs_pkg::BITS_DONE) begin
                    next_r.shreg = {r.shreg[6:0], r.sda_f};
                    next_r.cnt   = r.cnt + 4'H1;
                end else if (dec_rx) begin
                    next_r.state = ccs_pkg::ST_ACK;
                    next_r.oe    = 1'b1;
                    case (r.phase)
                        ccs_pkg::PH_ADDR: begin
                            // foreign address: stay off the line
                            if (!addr_match) begin
                                next_r.state = ccs_pkg::ST_IGNORE;
                                next_r.oe    = 1'b0;
                            end else begin
                                // direction bit picks read or write
                                next_r.rw       = r.shreg[0];
                                next_r.cnt_sent = 1'b0;
                                next_r.phase    = ccs_pkg::PH_CMD;
                            end
                        end
                        ccs_pkg::PH_CMD: begin
                            // access type from the top command bit
                            next_r.single = r.shreg[ccs_pkg::CMD_SINGLE];
                            // byte index, or zero for block access
                            next_r.index  = r.shreg[ccs_pkg::CMD_SINGLE] ? r.shreg[6:0] : 7'H00;
                            // count byte skipped in plain mode or for one byte
                            if (r.shreg[ccs_pkg::CMD_SINGLE] || plain_mode) begin
                                next_r.phase = ccs_pkg::PH_DATA;
                            end else begin
                                next_r.phase = ccs_pkg::PH_COUNT;
                            end
                        end
                        ccs_pkg::PH_COUNT: begin
                            // count value is not needed; the stop ends the block
                            next_r.phase = ccs_pkg::PH_DATA;
                        end
                        default: begin
                            // data byte acked only if the buffer takes it
                            if (fifo_in_ready) begin
                                next_r.index = r.index + 7'H01;
                            end else begin
                                next_r.state = ccs_pkg::ST_IGNORE;
                                next_r.oe    = 1'b0;
                            end
                        end
                    endcase
                end
            end
            ccs_pkg::ST_ACK: begin
                // release the ack after its clock, then carry on
                if (scl_fall) begin
                    next_r.oe = 1'b0;
                    if (r.rw) begin
                        do_load = 1'b1;
                    end else begin
                        next_r.state = ccs_pkg::ST_RX;
                        next_r.cnt   = 4'H0;
                    end
                end
            end
            ccs_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (r.cnt == ccs_pkg::BITS_DONE) begin
                        next_r.oe    = 1'b0;
                        next_r.state = ccs_pkg::ST_RACK;
                        next_r.cnt   = 4'H0;
                    end else begin
                        // next bit down, msb went first
                        next_r.oe    = ~r.shreg[6];
                        next_r.shreg = {r.shreg[6:0], 1'b0};
                        next_r.cnt   = r.cnt + 4'H1;
                    end
                end
            end
            ccs_pkg::ST_RACK: begin
                if (scl_rise) begin
                    next_r.cnt  = ccs_pkg::ACK_SEEN;
                    next_r.nack = r.sda_f;
                end else if (scl_fall && r.cnt == ccs_pkg::ACK_SEEN) begin
                    // not-ack ends the read; ack asks for more
                    if (r.nack) begin
                        next_r.state = ccs_pkg::ST_IGNORE;
                    end else begin
                        do_load = 1'b1;
                    end
                end
            end
            ccs_pkg::ST_IDLE, ccs_pkg::ST_IGNORE: begin
                next_r.oe = 1'b0;
            end
            default: begin
                next_r.state = ccs_pkg::ST_IDLE;
                next_r.oe    = 1'b0;
            end
        endcase

        // load a byte to send: count, block data or the indexed byte
        if (do_load) begin
            next_r.state = ccs_pkg::ST_TX;
            next_r.shreg = tx_byte;
            next_r.oe    = ~tx_byte[7];
            next_r.cnt   = 4'H1;
            if (!r.single && !r.cnt_sent) begin
                next_r.cnt_sent = 1'b1;
            end else begin
                next_r.index = r.index + 7'H01;
            end
        end

        // repeated start keeps command state, restarts address phase
        if (start_seen) begin
            next_r.state = ccs_pkg::ST_RX;
            next_r.phase = ccs_pkg::PH_ADDR;
            next_r.cnt   = 4'H0;
            next_r.oe    = 1'b0;
        end else if (stop_seen) begin
            next_r.state = ccs_pkg::ST_IDLE;
            next_r.oe    = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            r       <= '0;
            r.scl_s <= 3'H7;
            r.sda_s <= 3'H7;
            r.scl_f <= 1'b1;
            r.sda_f <= 1'b1;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.state <= ccs_pkg::ST_IDLE;
            r.phase <= ccs_pkg::PH_ADDR;
        end else begin
            r <= next_r;
        end
    end

    // written bytes queue here so a read never collides with a store write
    ccs_fifo #(
        .WIDTH (ccs_pkg::FIFO_WIDTH),
        .DEPTH (ccs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .reset     (RESET),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({r.index, r.shreg}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ccs_regs u_regs (
        .clk   (CLK),
        .reset (RESET),
        .rd    (mem_rd),
        .we    (fifo_out_valid),
        .addr  (mem_rd ? r.index : fifo_out_data[ccs_pkg::FIFO_WIDTH-1:8]),
        .wdata (fifo_out_data[7:0]),
        .rdata (mem_rdata),
        .bytes (CFG)
    );

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    addr_ack_a: assert property (dec_rx && r.phase == ccs_pkg::PH_ADDR && addr_match
        |=> SDA_OE ##1 SDA_OE)
        else $error("own address not acknowledged");

    foreign_addr_a: assert property (dec_rx && r.phase == ccs_pkg::PH_ADDR && !addr_match
        |=> !SDA_OE && r.state == ccs_pkg::ST_IGNORE)
        else $error("foreign address was acknowledged");

    cmd_mode_a: assert property (dec_rx && r.phase == ccs_pkg::PH_CMD
        |=> r.single == $past(r.shreg[7]))
        else $error("access type not taken from command bit 7");

    cmd_index_a: assert property (dec_rx && r.phase == ccs_pkg::PH_CMD
        |=> r.index == ($past(r.shreg[7]) ? $past(r.shreg[6:0]) : 7'H00))
        else $error("byte index not taken from command");

    count_skip_a: assert property (dec_rx && r.phase == ccs_pkg::PH_CMD && !r.shreg[7]
        |=> r.phase == (plain_mode ? ccs_pkg::PH_DATA : ccs_pkg::PH_COUNT))
        else $error("count byte phase wrong for mode");

    data_push_a: assert property (dec_rx && r.phase == ccs_pkg::PH_DATA && fifo_in_ready
        |-> fifo_in_valid ##1 SDA_OE)
        else $error("write data byte not stored and acked");

    count_first_a: assert property (do_load && !r.single && !r.cnt_sent
        |=> r.shreg == ccs_pkg::COUNT_BYTE && r.cnt_sent)
        else $error("block read did not open with the count");

    msb_first_a: assert property (r.state == ccs_pkg::ST_TX && scl_fall
        && r.cnt != ccs_pkg::BITS_DONE |=> SDA_OE == !$past(r.shreg[6]))
        else $error("transmit bit order wrong");

    nack_end_a: assert property (r.state == ccs_pkg::ST_RACK && scl_fall && r.nack
        && r.cnt == ccs_pkg::ACK_SEEN && !start_seen && !stop_seen
        |=> !SDA_OE [*2])
        else $error("slave kept driving after not-ack");

endmodule

/* test/ccs_host.sv */
`timescale 1ns/10ps
// bus controller model: drives the clock, pulls data low open-drain style
module ccs_host (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // idle bus at time zero, both lines high
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // wait whole system cycles; the lines move only on the falling edge
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask

    // start and repeated start; the low lead-in lets the slave drop its ack first
    task automatic start();
        sda_pull = 1'b0;
        ticks(6);
        scl = 1'b1;
        ticks(6);
        sda_pull = 1'b1;
        ticks(6);
        scl = 1'b0;
    endtask

    task automatic stop();
        ticks(1);
        sda_pull = 1'b1;
        ticks(5);
        scl = 1'b1;
        ticks(6);
        sda_pull = 1'b0;
        ticks(6);
    endtask

    // 320 ns bit, long low and short high: the slave answers about five cycles
    // after the fall, and its bit must settle before the rise reaches its filter
    task automatic one_bit(input logic b, output logic r);
        ticks(1);
        sda_pull = ~b;
        ticks(5);
        scl = 1'b1;
        ticks(2);
        r = sda;
        scl = 1'b0;
    endtask

    // msb first, then the ninth bit; ack_in low acknowledges a read byte
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], r[i]);
        end
        one_bit(ack_in, ack);
    endtask
endmodule

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
    logic        CLK;
    logic        RESET;
    logic        scl;
    logic        pull;
    wire         sda;
    logic        SDA_OE;
    logic        SDA_OUT;
    logic [63:0] CFG;
    logic [63:0] shadow;
    logic [7:0]  msg [0:11];
    logic [7:0]  d;
    logic        a;
    int          err_total;
    int          total_checks;
    // rows: byte index, written value, value read back
    logic [22:0] rows [0:5] = '{{7'H03, 8'HA5, 8'HA5}, {7'H00, 8'H3C, 8'H3C},
                                {7'H07, 8'H80, 8'H80}, {7'H05, 8'H5A, 8'H5A},
                                {7'H09, 8'H77, 8'H00}, {7'H7F, 8'H12, 8'H00}};

    // wire level: pulled up unless either party pulls it low
    assign sda = ~pull & (SDA_OE ? SDA_OUT : 1'b1);

    ccs_slave i_dut (
        .CLK     (CLK),
        .RESET   (RESET),
        .SCL     (scl),
        .SDA_IN  (sda),
        .SDA_OUT (SDA_OUT),
        .SDA_OE  (SDA_OE),
        .CFG     (CFG)
    );

    ccs_host u_host (
        .clk      (CLK),
        .sda      (sda),
        .scl      (scl),
        .sda_pull (pull)
    );

    // clock of 40 ns
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    task automatic close_out();
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // whole write transaction from msg, every byte must be acknowledged
    task automatic wr_msg(input int n);
        u_host.start();
        for (int i = 0; i < n; i++) begin
            u_host.xfer(msg[i], 1'b1, d, a);
            check(a, 1'b0);
        end
        u_host.stop();
    endtask

    // single byte write, shadow follows only the implemented bytes
    task automatic wr_byte(input logic [6:0] idx, input logic [7:0] v);
        msg[0] = 8'HD2;
        msg[1] = {1'b1, idx};
        msg[2] = v;
        wr_msg(3);
        if (idx < 7'H08) begin
            shadow[idx*8 +: 8] = v;
        end
    endtask

    // single byte read through a repeated start, closed by a not-ack
    task automatic rd_byte(input logic [6:0] idx, output logic [7:0] v);
        u_host.start();
        u_host.xfer(8'HD2, 1'b1, d, a);
        check(a, 1'b0);
        u_host.xfer({1'b1, idx}, 1'b1, d, a);
        check(a, 1'b0);
        u_host.start();
        u_host.xfer(8'HD3, 1'b1, d, a);
        check(a, 1'b0);
        u_host.xfer(8'HFF, 1'b1, v, a);
        u_host.stop();
    endtask

    // hang guard, a run far beyond the expected length counts as a failure
    initial begin
        repeat (100000) @(posedge CLK);
        err_total++;
        close_out();
    end

    // all configuration traffic happens right after reset, as at initialisation
    initial begin
        err_total    = 0;
        total_checks = 0;
        RESET        = 1'b1;
        shadow       = ccs_pkg::REG_DEFAULTS;
        repeat (6) @(negedge CLK);
        check(SDA_OE, 1'b0);
        RESET = 1'b0;
        repeat (8) @(negedge CLK);
        check(CFG, ccs_pkg::REG_DEFAULTS);
        // ordinary byte writes and reads, including indexes beyond the store
        for (int k = 0; k < 6; k++) begin
            wr_byte(rows[k][22:16], rows[k][15:8]);
            check(CFG, shadow);
            rd_byte(rows[k][22:16], d);
            check(d, rows[k][7:0]);
        end
        // block read of every byte, one byte past the end, last byte not-acked
        u_host.start();
        u_host.xfer(8'HD2, 1'b1, d, a);
        check(a, 1'b0);
        u_host.xfer(8'H00, 1'b1, d, a);
        check(a, 1'b0);
        u_host.start();
        u_host.xfer(8'HD3, 1'b1, d, a);
        check(a, 1'b0);
        u_host.xfer(8'HFF, 1'b0, d, a);
        check(d, 8'H08);
        for (int i = 0; i < 9; i++) begin
            u_host.xfer(8'HFF, i == 8, d, a);
            check(d, (i < 8) ? shadow[i*8 +: 8] : 8'H00);
        end
        u_host.stop();
        // foreign address: no ack, nothing after it acted on until next start
        u_host.start();
        u_host.xfer(8'HA4, 1'b1, d, a);
        check(a, 1'b1);
        u_host.xfer(8'H83, 1'b1, d, a);
        check(a, 1'b1);
        u_host.xfer(8'H00, 1'b1, d, a);
        check(a, 1'b1);
        u_host.stop();
        check(CFG, shadow);
        // block write with a count byte, data lands from byte zero upward
        msg = '{8'HD2, 8'H00, 8'H03, 8'H11, 8'H22, 8'H33, 8'H00, 8'H00,
                8'H00, 8'H00, 8'H00, 8'H00};
        wr_msg(6);
        shadow[23:0] = 24'H332211;
        check(CFG, shadow);
        // plain two-wire mode: the first byte after the command is already data
        wr_byte(7'H07, 8'H01);
        // the byte write left a single-byte command here; block access needs zero
        msg[1] = 8'H00;
        msg[2] = 8'H44;
        msg[3] = 8'H55;
        wr_msg(4);
        shadow[15:0] = 16'H5544;
        check(CFG, shadow);
        close_out();
    end
endmodule
